// File: core/vlan_filter_pkg.sv
package vlan_filter_pkg;

   // Switch geometry
   localparam int          NUM_PORTS   = 6;
   localparam int          PORT_W      = 6;
   localparam int          SRC_W       = 3;
   localparam int          DATA_W      = 16;
   localparam int          ADDR_W      = 5;

   // Management addressing: one device address per port
   localparam logic [4:0]  DEV_BASE    = 5'h08;
   localparam logic [4:0]  REG_CTRL    = 5'h04;
   localparam logic [4:0]  REG_MAP     = 5'h06;
   localparam logic [4:0]  REG_PAV     = 5'h0B;

   // Field positions
   localparam int          DB_LSB      = 12;
   localparam int          DB_W        = 4;
   localparam int          TUNNEL_BIT  = 7;
   localparam int          ING_MON_BIT = 15;

   // Reset values of the non-port-dependent fields
   localparam logic [3:0]  DB_RESET    = 4'h0;
   localparam logic        TUNNEL_RST  = 1'b0;
   localparam logic        ING_MON_RST = 1'b0;

   // Read-path state of the management port
   typedef enum logic [1:0] {
      RD_IDLE = 2'b01,
      RD_DATA = 2'b10
   } rd_state_t;

   // One-hot bit of a port inside a six-bit port vector
   function automatic logic [5:0] own_bit(input int p);
      own_bit = 6'(6'h01 << p);
   endfunction

   // Egress mask reset: every port except the port itself
   function automatic logic [5:0] mask_reset(input int p);
      mask_reset = 6'h3F & ~own_bit(p);
   endfunction

endpackage

// File: core/port_filter_regs.sv
`timescale 1ns/1ns
`default_nettype none

module port_filter_regs
   import vlan_filter_pkg::*;
#(
   parameter int PORT = 0
) (
   // Clock and resets
   input  wire logic              clk_i,
   input  wire logic              sys_rst_i,
   input  wire logic              soft_rst_i,
   // Register write port
   input  wire logic              wr_en_i,
   input  wire logic [ADDR_W-1:0] reg_addr_i,
   input  wire logic [DATA_W-1:0] wdata_i,
   // Register contents
   output logic      [PORT_W-1:0] egress_port_mask_o,
   output logic      [DB_W-1:0]   address_database_number_o,
   output logic                   mask_bypass_tunnel_o,
   output logic                   ingress_mirror_o,
   output logic      [PORT_W-1:0] port_association_vector_o
);

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         egress_port_mask_o        <= mask_reset(PORT);
         address_database_number_o <= DB_RESET;
      end else if (soft_rst_i) begin
         egress_port_mask_o        <= mask_reset(PORT);
         address_database_number_o <= DB_RESET;
      end else if (wr_en_i && reg_addr_i == REG_MAP) begin
         // Bits 11:6 are dropped on write
         egress_port_mask_o        <= wdata_i[PORT_W-1:0];
         address_database_number_o <= wdata_i[DB_LSB +: DB_W];
      end
   end

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         mask_bypass_tunnel_o <= TUNNEL_RST;
      end else if (soft_rst_i) begin
         mask_bypass_tunnel_o <= TUNNEL_RST;
      end else if (wr_en_i && reg_addr_i == REG_CTRL) begin
         mask_bypass_tunnel_o <= wdata_i[TUNNEL_BIT];
      end
   end

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         ingress_mirror_o          <= ING_MON_RST;
         port_association_vector_o <= own_bit(PORT);
      end else if (soft_rst_i) begin
         ingress_mirror_o          <= ING_MON_RST;
         port_association_vector_o <= own_bit(PORT);
      end else if (wr_en_i && reg_addr_i == REG_PAV) begin
         ingress_mirror_o          <= wdata_i[ING_MON_BIT];
         port_association_vector_o <= wdata_i[PORT_W-1:0];
      end
   end

endmodule

`default_nettype wire

// File: core/port_vlan_egress_filter.sv
`timescale 1ns/1ns
`default_nettype none

module port_vlan_egress_filter
   import vlan_filter_pkg::*;
(
   // Clock and resets
   input  wire logic              clk_i,
   input  wire logic              sys_rst_i,
   input  wire logic              soft_rst_i,
   // Management register port
   input  wire logic              mgmt_wr_i,
   input  wire logic              mgmt_rd_i,
   input  wire logic [ADDR_W-1:0] mgmt_dev_addr_i,
   input  wire logic [ADDR_W-1:0] mgmt_reg_addr_i,
   input  wire logic [DATA_W-1:0] mgmt_wdata_i,
   output logic      [DATA_W-1:0] mgmt_rdata_o,
   output logic                   mgmt_rvalid_o,
   // Lookup result from the address translation unit
   input  wire logic              lkp_valid_i,
   input  wire logic [SRC_W-1:0]  lkp_src_port_i,
   input  wire logic [PORT_W-1:0] lkp_dest_ports_i,
   input  wire logic              lkp_da_locked_i,
   // Filtered forwarding decision
   output logic                   fwd_valid_o,
   output logic      [PORT_W-1:0] fwd_ports_o,
   output logic      [PORT_W-1:0] fwd_mirror_o,
   output logic      [DB_W-1:0]   fwd_db_num_o
);

   localparam logic [ADDR_W-1:0] DEV_LAST = ADDR_W'(DEV_BASE + NUM_PORTS - 1);

   logic [PORT_W-1:0] mask_a   [NUM_PORTS];
   logic [DB_W-1:0]   db_a     [NUM_PORTS];
   logic              tunnel_a [NUM_PORTS];
   logic              ingmon_a [NUM_PORTS];
   logic [PORT_W-1:0] pav_a    [NUM_PORTS];

   logic              dev_hit;
   logic [SRC_W-1:0]  dev_idx;
   logic [DATA_W-1:0] rdata_d;
   rd_state_t         rd_state_q;

   // Device address decode, one address per port
   assign dev_hit = mgmt_dev_addr_i >= DEV_BASE && mgmt_dev_addr_i <= DEV_LAST;
   assign dev_idx = SRC_W'(mgmt_dev_addr_i - DEV_BASE);

   for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
      port_filter_regs #(
         .PORT                      (p)
      ) u_regs (
         .clk_i                     (clk_i),
         .sys_rst_i                 (sys_rst_i),
         .soft_rst_i                (soft_rst_i),
         .wr_en_i                   (mgmt_wr_i && dev_hit && dev_idx == SRC_W'(p)),
         .reg_addr_i                (mgmt_reg_addr_i),
         .wdata_i                   (mgmt_wdata_i),
         .egress_port_mask_o        (mask_a[p]),
         .address_database_number_o (db_a[p]),
         .mask_bypass_tunnel_o      (tunnel_a[p]),
         .ingress_mirror_o          (ingmon_a[p]),
         .port_association_vector_o (pav_a[p])
      );
   end

   // Register read image; reserved bits are zero
   always_comb begin
      rdata_d = '0;
      if (dev_hit) begin
         case (mgmt_reg_addr_i)
            REG_MAP: begin
               rdata_d[DB_LSB +: DB_W]  = db_a[dev_idx];
               rdata_d[PORT_W-1:0]      = mask_a[dev_idx];
            end
            REG_CTRL: begin
               rdata_d[TUNNEL_BIT]      = tunnel_a[dev_idx];
            end
            REG_PAV: begin
               rdata_d[ING_MON_BIT]     = ingmon_a[dev_idx];
               rdata_d[PORT_W-1:0]      = pav_a[dev_idx];
            end
            default: begin
               rdata_d = '0;
            end
         endcase
      end
   end

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         rd_state_q   <= RD_IDLE;
         mgmt_rdata_o <= 16'h0000;
      end else begin
         case (rd_state_q)
            RD_IDLE: begin
               if (mgmt_rd_i) begin
                  rd_state_q   <= RD_DATA;
                  mgmt_rdata_o <= rdata_d;
               end
            end
            RD_DATA: begin
               rd_state_q <= RD_IDLE;
               if (mgmt_rd_i) begin
                  rd_state_q   <= RD_DATA;
                  mgmt_rdata_o <= rdata_d;
               end
            end
            default: begin
               rd_state_q <= RD_IDLE;
            end
         endcase
      end
   end

   assign mgmt_rvalid_o = rd_state_q == RD_DATA;

   // Forwarding filter
   logic              src_ok;
   logic [SRC_W-1:0]  src;
   logic              bypass;
   logic [PORT_W-1:0] sel_mask;
   logic [PORT_W-1:0] ports_d;
   logic [PORT_W-1:0] mirror_d;

   assign src_ok   = lkp_src_port_i < SRC_W'(NUM_PORTS);
   assign src      = src_ok ? lkp_src_port_i : '0;
   assign sel_mask = mask_a[src];
   assign bypass   = tunnel_a[src] && lkp_da_locked_i;

   always_comb begin
      ports_d  = '0;
      mirror_d = '0;
      if (src_ok) begin
         // Own bit may be set by software, then hairpin is allowed
         ports_d = bypass ? lkp_dest_ports_i : lkp_dest_ports_i & sel_mask;
         for (int d = 0; d < NUM_PORTS; d++) begin
            if (ports_d[d]) begin
               mirror_d = mirror_d | (pav_a[d] & ~own_bit(d));
            end
         end
         if (ingmon_a[src]) begin
            mirror_d = mirror_d | (pav_a[src] & ~own_bit(int'(src)));
         end
      end
   end

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         fwd_valid_o  <= 1'b0;
         fwd_ports_o  <= 6'h00;
         fwd_mirror_o <= 6'h00;
         fwd_db_num_o <= 4'h0;
      end else begin
         fwd_valid_o <= lkp_valid_i;
         if (lkp_valid_i) begin
            fwd_ports_o  <= ports_d;
            fwd_mirror_o <= mirror_d;
            fwd_db_num_o <= src_ok ? db_a[src] : 4'h0;
         end
      end
   end

   // Checks
   sequence s_map_write;
      mgmt_wr_i && dev_hit && mgmt_reg_addr_i == REG_MAP;
   endsequence

   sequence s_read_req;
      mgmt_rd_i && dev_hit && mgmt_reg_addr_i == REG_MAP;
   endsequence

   a_db_on_output: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      lkp_valid_i && src_ok |=> fwd_db_num_o == $past(db_a[src]))
      else $error("database number does not follow source port");

   a_reserved_read: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      s_read_req |=> mgmt_rvalid_o && mgmt_rdata_o[11:6] == 6'h00)
      else $error("reserved map bits read non-zero");

   a_mask_limits: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      lkp_valid_i && !bypass |=> (fwd_ports_o & ~$past(sel_mask)) == 6'h00)
      else $error("frame forwarded outside egress mask");

   a_tunnel_pass: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      lkp_valid_i && src_ok && bypass |=> fwd_ports_o == $past(lkp_dest_ports_i))
      else $error("tunnel frame was masked");

   a_mask_reset: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      soft_rst_i |=> mask_a[0] == 6'h3E && mask_a[1] == 6'h3D && mask_a[2] == 6'h3B
                     && mask_a[5] == 6'h1F)
      else $error("egress mask reset value wrong");

   a_write_then_read: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      s_map_write ##1 (s_read_req and (!mgmt_wr_i && !soft_rst_i
                       && $past(mgmt_dev_addr_i) == mgmt_dev_addr_i))
      |=> mgmt_rdata_o == ($past(mgmt_wdata_i, 2) & 16'hF03F))
      else $error("map write not seen on readback");

   a_hairpin_own: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      lkp_valid_i && src_ok && sel_mask[src] && lkp_dest_ports_i[src]
      |=> fwd_ports_o[$past(src)])
      else $error("own-port bit set but hairpin blocked");

   a_ingress_copy: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      lkp_valid_i && src_ok && ingmon_a[src]
      |=> (($past(pav_a[src]) & ~own_bit(int'($past(src)))) & ~fwd_mirror_o) == 6'h00)
      else $error("ingress mirror copy missing");

   a_no_mirror_idle: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      lkp_valid_i && src_ok && lkp_dest_ports_i == 6'h00 && !ingmon_a[src]
      |=> fwd_mirror_o == 6'h00)
      else $error("mirror copy without any egress port");

endmodule

`default_nettype wire

// File: verif/mgmt_host_model.sv
`timescale 1ns/1ns
`default_nettype none

// Management processor: one-cycle strobes launched at the falling edge
module mgmt_host_model
   import vlan_filter_pkg::*;
(
   // Clock
   input  wire logic              clk_i,
   // Read answer
   input  wire logic              rvalid_i,
   input  wire logic [DATA_W-1:0] rdata_i,
   // Request
   output logic                   wr_o,
   output logic                   rd_o,
   output logic      [ADDR_W-1:0] dev_o,
   output logic      [ADDR_W-1:0] reg_o,
   output logic      [DATA_W-1:0] wdata_o
);
   initial begin
      wr_o    = 1'b0;
      rd_o    = 1'b0;
      dev_o   = '0;
      reg_o   = '0;
      wdata_o = '0;
   end

   task automatic access(input logic w, input logic [4:0] d, input logic [4:0] r,
                         input logic [15:0] v, output logic [15:0] q);
      @(negedge clk_i);
      wr_o    = w;
      rd_o    = ~w;
      dev_o   = d;
      reg_o   = r;
      wdata_o = v;
      @(negedge clk_i);
      q       = rvalid_i ? rdata_i : 'x;
      wr_o    = 1'b0;
      rd_o    = 1'b0;
      // Released lines show the inverse of the last value
      dev_o   = ~d;
      reg_o   = ~r;
      wdata_o = ~v;
   endtask

   // Write followed directly by a read of the same register
   task automatic wr_then_rd(input logic [4:0] d, input logic [4:0] r, input logic [15:0] v,
                             output logic [15:0] q);
      @(negedge clk_i);
      wr_o    = 1'b1;
      rd_o    = 1'b0;
      dev_o   = d;
      reg_o   = r;
      wdata_o = v;
      @(negedge clk_i);
      wr_o    = 1'b0;
      rd_o    = 1'b1;
      @(negedge clk_i);
      q       = rvalid_i ? rdata_i : 'x;
      rd_o    = 1'b0;
      dev_o   = ~d;
      reg_o   = ~r;
      wdata_o = ~v;
   endtask
endmodule

`default_nettype wire

// File: verif/tb_top.sv
`timescale 1ns/1ns
`default_nettype none

module tb_top;
   import vlan_filter_pkg::*;
   logic              clk_i = 1'b0;
   logic              sys_rst_i = 1'b1;
   logic              soft_rst_i = 1'b0;
   logic              lkp_valid_i = 1'b0;
   logic              lkp_da_locked_i = 1'b0;
   logic [SRC_W-1:0]  lkp_src_port_i = '0;
   logic [PORT_W-1:0] lkp_dest_ports_i = '0;
   logic              wr, rd, rvalid, fwd_valid;
   logic [ADDR_W-1:0] dev, rg;
   logic [DATA_W-1:0] wdata, rdata;
   logic [PORT_W-1:0] fwd_ports, fwd_mirror;
   logic [DB_W-1:0]   fwd_db;
   int                failures = 0;
   int                num_checks = 0;
   int                cycles = 0;

   always #5 clk_i = ~clk_i;

   mgmt_host_model host (.clk_i(clk_i), .rvalid_i(rvalid), .rdata_i(rdata), .wr_o(wr),
      .rd_o(rd), .dev_o(dev), .reg_o(rg), .wdata_o(wdata));

   port_vlan_egress_filter uut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .soft_rst_i(soft_rst_i),
      .mgmt_wr_i(wr), .mgmt_rd_i(rd), .mgmt_dev_addr_i(dev), .mgmt_reg_addr_i(rg),
      .mgmt_wdata_i(wdata), .mgmt_rdata_o(rdata), .mgmt_rvalid_o(rvalid),
      .lkp_valid_i(lkp_valid_i), .lkp_src_port_i(lkp_src_port_i),
      .lkp_dest_ports_i(lkp_dest_ports_i), .lkp_da_locked_i(lkp_da_locked_i),
      .fwd_valid_o(fwd_valid), .fwd_ports_o(fwd_ports), .fwd_mirror_o(fwd_mirror),
      .fwd_db_num_o(fwd_db));

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         failures++;
         $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wr_reg(input logic [4:0] d, input logic [4:0] r, input logic [15:0] v);
      logic [15:0] q;
      host.access(1'b1, d, r, v, q);
   endtask

   task automatic rd_reg(input logic [4:0] d, input logic [4:0] r, input logic [15:0] exp);
      logic [15:0] q;
      host.access(1'b0, d, r, 16'h0000, q);
      check(q, exp);
   endtask

   // One lookup; the answer is judged at the falling edge, half a cycle after the rising edge that takes it
   task automatic lookup(input logic [2:0] s, input logic [5:0] dst, input logic lk,
                         input logic [5:0] ep, input logic [5:0] em, input logic [3:0] ed);
      @(negedge clk_i);
      lkp_valid_i      = 1'b1;
      lkp_src_port_i   = s;
      lkp_dest_ports_i = dst;
      lkp_da_locked_i  = lk;
      @(negedge clk_i);
      lkp_valid_i      = 1'b0;
      lkp_dest_ports_i = ~dst;
      check({15'h0000, fwd_valid}, 16'h0001);
      check({10'h000, fwd_ports}, {10'h000, ep});
      check({10'h000, fwd_mirror}, {10'h000, em});
      check({12'h000, fwd_db}, {12'h000, ed});
   endtask

   task automatic test_reset();
      logic [5:0] own;
      for (int p = 0; p < 6; p++) begin
         own = 6'(6'h01 << p);
         rd_reg(5'(8 + p), REG_MAP, {10'h000, 6'h3F & ~own});
         rd_reg(5'(8 + p), REG_PAV, {10'h000, own});
         rd_reg(5'(8 + p), REG_CTRL, 16'h0000);
      end
      $display("test reset done");
   endtask

   task automatic test_reserved();
      logic [15:0] q;
      wr_reg(5'h0A, REG_MAP, 16'hFFFF);
      rd_reg(5'h0A, REG_MAP, 16'hF03F);
      wr_reg(5'h0A, REG_CTRL, 16'hFFFF);
      rd_reg(5'h0A, REG_CTRL, 16'h0080);
      wr_reg(5'h0E, REG_MAP, 16'hFFFF);
      rd_reg(5'h0E, REG_MAP, 16'h0000);
      rd_reg(5'h0A, 5'h05, 16'h0000);
      host.wr_then_rd(5'h0B, REG_MAP, 16'h5FC9, q);
      check(q, 16'h5009);
      $display("test reserved done");
   endtask

   task automatic test_filter();
      lookup(3'h0, 6'h3F, 1'b0, 6'h3E, 6'h00, 4'h0);
      lookup(3'h2, 6'h3F, 1'b0, 6'h3F, 6'h00, 4'hF);
      lookup(3'h6, 6'h3F, 1'b0, 6'h00, 6'h00, 4'h0);
      lookup(3'h0, 6'h00, 1'b0, 6'h00, 6'h00, 4'h0);
      $display("test filter done");
   endtask

   task automatic test_soft();
      @(negedge clk_i);
      soft_rst_i = 1'b1;
      @(negedge clk_i);
      soft_rst_i = 1'b0;
      rd_reg(5'h0A, REG_MAP, 16'h003B);
      rd_reg(5'h0A, REG_CTRL, 16'h0000);
      $display("test soft reset done");
   endtask

   task automatic test_tunnel();
      wr_reg(5'h09, REG_MAP, 16'h1001);
      lookup(3'h1, 6'h3E, 1'b1, 6'h00, 6'h00, 4'h1);
      wr_reg(5'h09, REG_CTRL, 16'h0080);
      lookup(3'h1, 6'h3E, 1'b1, 6'h3E, 6'h00, 4'h1);
      lookup(3'h1, 6'h3E, 1'b0, 6'h00, 6'h00, 4'h1);
      $display("test tunnel done");
   endtask

   task automatic test_mirror();
      wr_reg(5'h09, REG_PAV, 16'h0003);
      lookup(3'h0, 6'h02, 1'b0, 6'h02, 6'h01, 4'h0);
      wr_reg(5'h09, REG_PAV, 16'h8003);
      rd_reg(5'h09, REG_PAV, 16'h8003);
      lookup(3'h1, 6'h04, 1'b0, 6'h00, 6'h01, 4'h1);
      $display("test mirror done");
   endtask

   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 2000) begin
         failures++;
         give_verdict();
      end
   end

   initial begin
      repeat (20) @(negedge clk_i);
      sys_rst_i = 1'b0;
      test_reset();
      test_reserved();
      test_filter();
      test_soft();
      test_tunnel();
      test_mirror();
      give_verdict();
   end
endmodule

`default_nettype wire
